// ===== logic/ald_pkg.sv
/*
 * constants, opcodes and register map of the add and logic datapath.
 * assumes one core clock and a synchronous active-high core reset.
 */
package ald_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 2;
    localparam int OP_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes
    typedef enum logic [2:0] {
        SUM_WITH_CARRY_OP        = 3'h0,
        SUM_WITH_CARRY_TO_MEM_OP = 3'h1,
        SUM_MEM_OP               = 3'h2,
        SUM_LITERAL_OP           = 3'h3,
        SUM_TO_MEMORY_OP         = 3'h4,
        CONJ_MEM_OP              = 3'h5,
        CONJ_LITERAL_OP          = 3'h6,
        BITWISE_CONJ_TO_MEMORY_OP = 3'h7
    } ald_op_t;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [1:0] REG_WORKING = 2'h0;
    localparam logic [1:0] REG_FLAGS = 2'h1;
    localparam logic [1:0] REG_RESULT = 2'h2;

    // flag field positions
    localparam int FLAG_UPPER_SPILL = 0;
    localparam int FLAG_HALF_CARRY = 1;
    localparam int FLAG_ALL_LOW = 2;
    localparam int FLAG_SIGNED_WRAP = 3;
    localparam int FLAG_W = 4;

    // values after reset
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // cycles per instruction
    localparam int OP_CYCLES = 1;

endpackage

// ===== logic/ald_adder.sv
/*
 * 8-bit adder with carry in, giving carry out of bit 3, bit 7 and the
 * two's-complement overflow. purely combinational.
 */
module ald_adder
(
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic carry_i,
    output logic [7:0] sum_o,
    output logic carry3_o,
    output logic carry7_o,
    output logic wrap_o
);

    logic [4:0] low;
    logic [3:0] mid;
    logic [1:0] top;

    always_comb
    begin
        low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_i};
        mid = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, low[4]};
        top = {1'b0, a_i[7]} + {1'b0, b_i[7]} + {1'b0, mid[3]};
        sum_o = {top[0], mid[2:0], low[3:0]};
        carry3_o = low[4];
        carry7_o = top[1];
        // carry into bit 7 differs from carry out
        wrap_o = top[1] ^ mid[3];
    end

endmodule

// ===== logic/ald_datapath.sv
/*
 * add, add-with-carry and AND datapath of an 8-bit core, with the
 * working register, four arithmetic flags and a small register port.
 * assumes the core presents the addressed memory byte and the literal
 * beside op_valid_i, and performs the memory write on mem_wr_o.
 */
// Function
// - carry add from memory into working register
// - carry add written back to memory
// - plain add from memory into working register
// - plain add of literal into working register
// - plain add written back to memory
// - AND with memory, only zero flag
// - AND with literal, only zero flag
// - AND written back to memory, zero flag
module ald_datapath
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic op_valid_i,
    input wire logic [2:0] op_code_i,
    input wire logic [7:0] mem_data_i,
    input wire logic [7:0] literal_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] working_reg_o,
    output logic upper_spill_flag_o,
    output logic half_carry_flag_o,
    output logic all_bits_low_flag_o,
    output logic signed_wrap_flag_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic op_done_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == 8'h00);
    endfunction

    function automatic logic [7:0] pack_flags(input logic [3:0] flags);
        pack_flags = {4'h0, flags};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // operand selection and adder

    ald_pkg::ald_op_t op;
    logic uses_literal;
    logic uses_carry;
    logic [7:0] operand_b;
    logic [7:0] sum;
    logic [7:0] conj;
    logic carry3;
    logic carry7;
    logic wrap;

    always_comb
    begin
        op = ald_pkg::ald_op_t'(op_code_i);
        uses_literal = (op == ald_pkg::SUM_LITERAL_OP) || (op == ald_pkg::CONJ_LITERAL_OP);
        uses_carry = (op == ald_pkg::SUM_WITH_CARRY_OP)
            || (op == ald_pkg::SUM_WITH_CARRY_TO_MEM_OP);
        operand_b = uses_literal ? literal_i : mem_data_i;
        conj = working_reg_o & operand_b;
    end

    ald_adder u_adder
    (
        .a_i(working_reg_o),
        .b_i(operand_b),
        .carry_i(uses_carry & upper_spill_flag_o),
        .sum_o(sum),
        .carry3_o(carry3),
        .carry7_o(carry7),
        .wrap_o(wrap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] result;
    logic [3:0] flags;
    logic [7:0] next_working;
    logic [3:0] next_flags;
    logic [7:0] next_result;
    logic [7:0] next_rdata;
    logic next_mem_wr;
    logic [7:0] next_mem_wdata;
    logic next_done;

    always_comb
    begin
        next_working = working_reg_o;
        next_flags = flags;
        next_result = result;
        next_mem_wr = 1'b0;
        next_mem_wdata = mem_wdata_o;
        next_done = 1'b0;
        next_rdata = ald_pkg::READ_IDLE;
        // software writes; an instruction in the same cycle wins, except over a working register write beside a to-memory op
        if (reg_wr_i)
        begin
            if (reg_addr_i == ald_pkg::REG_WORKING)
            begin
                next_working = reg_wdata_i;
            end
            if (reg_addr_i == ald_pkg::REG_FLAGS)
            begin
                next_flags = reg_wdata_i[ald_pkg::FLAG_W-1:0];
            end
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ald_pkg::REG_WORKING: next_rdata = working_reg_o;
                ald_pkg::REG_FLAGS: next_rdata = pack_flags(flags);
                ald_pkg::REG_RESULT: next_rdata = result;
                default: next_rdata = ald_pkg::READ_IDLE;
            endcase
        end
        if (op_valid_i)
        begin
            next_done = 1'b1;
            next_flags = flags;
            unique case (op)
                ald_pkg::SUM_WITH_CARRY_OP,
                ald_pkg::SUM_MEM_OP,
                ald_pkg::SUM_LITERAL_OP:
                begin
                    next_working = sum;
                    next_result = sum;
                end
                ald_pkg::SUM_WITH_CARRY_TO_MEM_OP,
                ald_pkg::SUM_TO_MEMORY_OP:
                begin
                    next_mem_wr = 1'b1;
                    next_mem_wdata = sum;
                    next_result = sum;
                end
                ald_pkg::CONJ_MEM_OP,
                ald_pkg::CONJ_LITERAL_OP:
                begin
                    next_working = conj;
                    next_result = conj;
                end
                ald_pkg::BITWISE_CONJ_TO_MEMORY_OP:
                begin
                    next_mem_wr = 1'b1;
                    next_mem_wdata = conj;
                    next_result = conj;
                end
            endcase
            if (op inside {ald_pkg::CONJ_MEM_OP, ald_pkg::CONJ_LITERAL_OP,
                ald_pkg::BITWISE_CONJ_TO_MEMORY_OP})
            begin
                next_flags[ald_pkg::FLAG_ALL_LOW] = is_zero(conj);
            end
            else
            begin
                next_flags[ald_pkg::FLAG_UPPER_SPILL] = carry7;
                next_flags[ald_pkg::FLAG_HALF_CARRY] = carry3;
                next_flags[ald_pkg::FLAG_ALL_LOW] = is_zero(sum);
                next_flags[ald_pkg::FLAG_SIGNED_WRAP] = wrap;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            working_reg_o <= ald_pkg::WORKING_RESET;
            flags <= ald_pkg::FLAGS_RESET;
            result <= ald_pkg::RESULT_RESET;
            reg_rdata_o <= ald_pkg::READ_IDLE;
            mem_wr_o <= 1'b0;
            mem_wdata_o <= ald_pkg::RESULT_RESET;
            op_done_o <= 1'b0;
        end
        else
        begin
            working_reg_o <= next_working;
            flags <= next_flags;
            result <= next_result;
            reg_rdata_o <= next_rdata;
            mem_wr_o <= next_mem_wr;
            mem_wdata_o <= next_mem_wdata;
            op_done_o <= next_done;
        end
    end

    assign upper_spill_flag_o = flags[ald_pkg::FLAG_UPPER_SPILL];
    assign half_carry_flag_o = flags[ald_pkg::FLAG_HALF_CARRY];
    assign all_bits_low_flag_o = flags[ald_pkg::FLAG_ALL_LOW];
    assign signed_wrap_flag_o = flags[ald_pkg::FLAG_SIGNED_WRAP];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    logic [7:0] w_q;
    logic [7:0] m_q;
    logic [7:0] l_q;
    logic c_q;
    logic [8:0] ref_sum;

    always_ff @(posedge core_clk_i)
    begin
        w_q <= working_reg_o;
        m_q <= mem_data_i;
        l_q <= literal_i;
        c_q <= upper_spill_flag_o;
    end

    always_comb
    begin
        ref_sum = {1'b0, w_q} + {1'b0, m_q} + {8'h00, c_q};
    end

    sequence s_op_issued(logic [2:0] code);
        op_valid_i && (op_code_i == code);
    endsequence

    // memory byte written, working register left alone
    sequence s_mem_written(logic [7:0] value);
        mem_wr_o && (mem_wdata_o == value) && (working_reg_o == w_q);
    endsequence

    a_carry_add_acc: assert property (
        op_valid_i && op == ald_pkg::SUM_WITH_CARRY_OP
        |=> working_reg_o == ref_sum[7:0] && upper_spill_flag_o == ref_sum[8]
            && !mem_wr_o)
        else $error("carry add into working register wrong");

    a_carry_add_mem: assert property (
        s_op_issued(ald_pkg::SUM_WITH_CARRY_TO_MEM_OP)
        |=> s_mem_written(ref_sum[7:0])
            ##0 ((upper_spill_flag_o == ref_sum[8])
            && (all_bits_low_flag_o == (ref_sum[7:0] == 8'h00))))
        else $error("carry add to memory wrong");

    a_plain_add_acc: assert property (
        op_valid_i && op == ald_pkg::SUM_MEM_OP
        |=> working_reg_o == 8'(w_q + m_q))
        else $error("plain add from memory wrong");

    a_literal_add: assert property (
        op_valid_i && op == ald_pkg::SUM_LITERAL_OP
        |=> working_reg_o == 8'(w_q + l_q) && all_bits_low_flag_o == (working_reg_o == 8'h00))
        else $error("literal add wrong");

    a_plain_add_mem: assert property (
        op_valid_i && op == ald_pkg::SUM_TO_MEMORY_OP
        |=> mem_wr_o && mem_wdata_o == 8'(w_q + m_q) && working_reg_o == w_q)
        else $error("plain add to memory wrong");

    a_conj_mem_acc: assert property (
        op_valid_i && op == ald_pkg::CONJ_MEM_OP
        |=> working_reg_o == (w_q & m_q) && $stable(upper_spill_flag_o)
            && $stable(half_carry_flag_o) && $stable(signed_wrap_flag_o))
        else $error("and with memory wrong");

    a_conj_literal: assert property (
        op_valid_i && op == ald_pkg::CONJ_LITERAL_OP
        |=> working_reg_o == (w_q & l_q) && $stable(upper_spill_flag_o))
        else $error("and with literal wrong");

    a_conj_to_mem: assert property (
        op_valid_i && op == ald_pkg::BITWISE_CONJ_TO_MEMORY_OP
        |=> mem_wr_o && mem_wdata_o == (w_q & m_q) && working_reg_o == w_q
            && all_bits_low_flag_o == ((w_q & m_q) == 8'h00))
        else $error("and to memory wrong");

    a_half_carry: assert property (
        op_valid_i && op == ald_pkg::SUM_MEM_OP
        |=> half_carry_flag_o == ((5'(w_q[3:0]) + 5'(m_q[3:0])) > 5'h0F)
            && signed_wrap_flag_o == ((w_q[7] == m_q[7]) && (working_reg_o[7] != w_q[7])))
        else $error("half carry or wrap flag wrong");

    a_one_cycle: assert property (
        op_valid_i |=> op_done_o ##1 (op_done_o == $past(op_valid_i)))
        else $error("instruction not done in one cycle");

    a_flags_hold: assert property (
        !op_valid_i && !(reg_wr_i && reg_addr_i == ald_pkg::REG_FLAGS)
        |=> $stable(flags))
        else $error("flags changed without cause");

    a_mem_write_src: assert property (
        mem_wr_o |-> $past(op_valid_i))
        else $error("memory write without an instruction");

endmodule

// ===== tb/tb_add_and_logic_datapath.sv
/*
 * self-checking bench of the add and logic datapath: every opcode, flag
 * edge cases, register port reads and writes.
 * assumes ald_pkg and ald_datapath are compiled first; one 250 MHz clock.
 */
module tb_add_and_logic_datapath;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_i, reset_i, op_valid_i, reg_wr_i, reg_rd_i;
    logic [2:0] op_code_i;
    logic [7:0] mem_data_i, literal_i, reg_wdata_i;
    logic [1:0] reg_addr_i;
    logic [7:0] reg_rdata_o, working_reg_o, mem_wdata_o;
    logic upper_spill_flag_o, half_carry_flag_o, all_bits_low_flag_o, signed_wrap_flag_o;
    logic mem_wr_o, op_done_o;
    int err_count, check_count;
    logic [7:0] m_work, m_res;
    logic [3:0] m_flags;

    ald_datapath i_dut (.core_clk_i, .reset_i, .op_valid_i, .op_code_i, .mem_data_i,
        .literal_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .working_reg_o, .upper_spill_flag_o, .half_carry_flag_o, .all_bits_low_flag_o,
        .signed_wrap_flag_o, .mem_wr_o, .mem_wdata_o, .op_done_o);

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] flg();
        return {4'h0, signed_wrap_flag_o, all_bits_low_flag_o, half_carry_flag_o,
            upper_spill_flag_o};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        if (a == ald_pkg::REG_WORKING)
            m_work = d;
        if (a == ald_pkg::REG_FLAGS)
            m_flags = d[3:0];
    endtask

    task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp, "read data");
        @(posedge core_clk_i);
        #1 chk(reg_rdata_o, 8'h00, "read data idle");
    endtask

    // one instruction against the bench model, results one cycle later
    task automatic run_op(input logic [2:0] op, input logic [7:0] m, input logic [7:0] lit);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b, r;
        logic [3:0] f;
        logic cin, to_mem, is_and;
        is_and = op >= 3'h5;
        to_mem = op == 3'h1 || op == 3'h4 || op == 3'h7;
        b = (op == 3'h3 || op == 3'h6) ? lit : m;
        cin = (op <= 3'h1) ? m_flags[ald_pkg::FLAG_UPPER_SPILL] : 1'b0;
        s = {1'b0, m_work} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, m_work[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r = is_and ? (m_work & b) : s[7:0];
        f = m_flags;
        f[ald_pkg::FLAG_ALL_LOW] = (r == 8'h00);
        if (!is_and)
        begin
            f[ald_pkg::FLAG_UPPER_SPILL] = s[8];
            f[ald_pkg::FLAG_HALF_CARRY] = h[4];
            f[ald_pkg::FLAG_SIGNED_WRAP] = (m_work[7] == b[7]) && (r[7] != m_work[7]);
        end
        @(posedge core_clk_i);
        op_valid_i <= 1'b1;
        op_code_i <= op;
        mem_data_i <= m;
        literal_i <= lit;
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        #1 chk({7'h00, op_done_o}, 8'h01, "done pulse");
        chk(working_reg_o, to_mem ? m_work : r, "working register");
        chk(flg(), {4'h0, f}, "flags");
        chk({7'h00, mem_wr_o}, {7'h00, to_mem}, "memory write strobe");
        if (to_mem)
            chk(mem_wdata_o, r, "memory write data");
        if (!to_mem)
            m_work = r;
        m_flags = f;
        m_res = r;
        @(posedge core_clk_i);
        #1 chk({6'h00, op_done_o, mem_wr_o}, 8'h00, "pulses one cycle");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(working_reg_o, 8'h00, "reset working");
        chk(flg(), 8'h00, "reset flags");
        reg_rd(ald_pkg::REG_RESULT, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_adds();
        reg_wr(ald_pkg::REG_WORKING, 8'h0F);
        reg_wr(ald_pkg::REG_FLAGS, 8'h01);
        run_op(ald_pkg::SUM_WITH_CARRY_OP, 8'h00, 8'hAA);
        reg_wr(ald_pkg::REG_FLAGS, 8'h01);
        run_op(ald_pkg::SUM_WITH_CARRY_TO_MEM_OP, 8'h70, 8'hAA);
        reg_wr(ald_pkg::REG_FLAGS, 8'h01);
        run_op(ald_pkg::SUM_MEM_OP, 8'hF0, 8'h55);
        run_op(ald_pkg::SUM_LITERAL_OP, 8'h55, 8'hFF);
        run_op(ald_pkg::SUM_TO_MEMORY_OP, 8'h01, 8'h00);
        $display("test adds done");
    endtask

    task automatic t_ands();
        reg_wr(ald_pkg::REG_FLAGS, 8'h0B);
        run_op(ald_pkg::CONJ_MEM_OP, 8'h0F, 8'h00);
        run_op(ald_pkg::CONJ_LITERAL_OP, 8'hFF, 8'hF0);
        reg_wr(ald_pkg::REG_WORKING, 8'hA5);
        run_op(ald_pkg::BITWISE_CONJ_TO_MEMORY_OP, 8'h5A, 8'hFF);
        $display("test ands done");
    endtask

    // flags write in the same cycle as an and: the instruction wins
    task automatic t_clash();
        @(posedge core_clk_i);
        reg_addr_i <= ald_pkg::REG_FLAGS;
        reg_wdata_i <= 8'h00;
        reg_wr_i <= 1'b1;
        op_valid_i <= 1'b1;
        op_code_i <= ald_pkg::CONJ_LITERAL_OP;
        literal_i <= 8'h00;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        op_valid_i <= 1'b0;
        #1 chk(working_reg_o, m_work & 8'h00, "working after clash");
        m_flags[ald_pkg::FLAG_ALL_LOW] = 1'b1;
        chk(flg(), {4'h0, m_flags}, "flags after clash");
        m_work = 8'h00;
        m_res = 8'h00;
        $display("test clash done");
    endtask

    task automatic t_regs();
        reg_rd(ald_pkg::REG_RESULT, m_res);
        reg_wr(ald_pkg::REG_RESULT, 8'h3C);
        reg_wr(2'h3, 8'hC3);
        reg_rd(ald_pkg::REG_RESULT, m_res);
        reg_rd(2'h3, 8'h00);
        reg_rd(ald_pkg::REG_FLAGS, {4'h0, m_flags});
        reg_rd(ald_pkg::REG_WORKING, m_work);
        $display("test registers done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2000) @(posedge core_clk_i);
        err_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        finish_test();
    end

    initial
    begin
        err_count = 0;
        check_count = 0;
        m_work = 8'h00;
        m_flags = 4'h0;
        m_res = 8'h00;
        reset_i = 1'b1;
        op_valid_i = 1'b0;
        op_code_i = 3'h0;
        mem_data_i = 8'h00;
        literal_i = 8'h00;
        reg_addr_i = 2'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1 t_reset();
        t_adds();
        t_ands();
        t_clash();
        t_regs();
        finish_test();
    end
endmodule
